// ---- test/scsw_clock_switch_tb.sv ----
// Self-checking bench for the system clock switch
`timescale 1ns/100ps
module scsw_clock_switch_tb;
	logic clk = 0, rst = 1, clk_en = 1, pwr_done = 0, sleep_cmd = 0, wake_event = 0;
	logic sel_wr = 0, sec_en = 0, irq_en = 0, fail_clr = 0, ext_run = 1, chk_req = 0;
	logic [1:0] sel_wdata = 2'h0;
	logic [3:0] ifs = 4'h7, ifa;
	logic [31:0] seed = 32'hc188_bc21;
	scsw_pkg::scsw_cfg_t cfg = '{scsw_pkg::MODE_STD_XTAL, 1'b1, 1'b1};
	scsw_pkg::scsw_osc_t osc;
	scsw_pkg::scsw_src_t sys_src;
	logic sec_stable, sts, rdy, run, flag, irq, fs, hold, cpu_run;
	logic [1:0] sel;
	logic hold_seen = 0;
	logic [7:0] exp_q[$];
	int mismatches = 0, checks_done = 0, cycles = 0, i;

	always #20 clk = ~clk;

	scsw_osc_model i_scsw_osc_model (.clk(clk), .rst(rst), .ext_run(ext_run),
		.sec_enable(sec_en), .osc(osc), .sec_stable(sec_stable));
	scsw_clock_switch i_scsw_clock_switch (.clk(clk), .rst(rst), .clk_en(clk_en), .cfg(cfg),
		.power_delay_done(pwr_done), .sleep_cmd(sleep_cmd), .wake_event(wake_event),
		.sel_wr(sel_wr), .sel_wdata(sel_wdata), .int_freq_select(ifs),
		.secondary_osc_enable(sec_en), .osc_fail_irq_enable(irq_en),
		.osc_fail_clear(fail_clr), .osc(osc), .sec_osc_stable(sec_stable),
		.sys_clk_select(sel), .startup_timer_status(sts), .secondary_osc_ready(rdy),
		.secondary_osc_run(run), .osc_fail_flag(flag), .osc_fail_irq(irq),
		.fail_safe_active(fs), .int_freq_active(ifa), .sys_src(sys_src),
		.clk_hold_low(hold), .cpu_run(cpu_run));

	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function logic [7:0] ex(input logic st, input logic fl, input logic f,
		input logic [1:0] sl, input scsw_pkg::scsw_src_t src, input logic r);
		return {st, fl, f, sl, src, r};
	endfunction

	task check(input logic [7:0] seen, input logic [7:0] expv);
		checks_done++;
		if (seen !== expv) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	task end_of_test;
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Note an expectation; the watcher compares it at the next edge
	task note(input logic [7:0] e);
		exp_q.push_back(e);
		chk_req = 1;
		@(negedge clk);
		chk_req = 0;
	endtask

	always @(posedge clk) begin
		if (chk_req && exp_q.size() > 0) begin
			#1;
			check({sts, flag, fs, sel, sys_src, cpu_run}, exp_q.pop_front());
		end
	end

	// Hold-low lasts only until the next crystal fall, so latch that it occurred
	always @(negedge clk) begin
		if (hold) hold_seen = 1;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			end_of_test();
		end
	end

	task wait_src(input scsw_pkg::scsw_src_t s, input int lim);
		for (i = 0; i < lim && sys_src !== s; i++) @(negedge clk);
	endtask

	task pulse_sel(input logic [1:0] v);
		sel_wr = 1;
		sel_wdata = v;
		@(negedge clk);
		sel_wr = 0;
	endtask

	task restart(input scsw_pkg::scsw_cfg_t c);
		cfg = c;
		rst = 1;
		repeat (2) @(negedge clk);
		rst = 0;
	endtask

	initial begin
		seed = lfsr(seed);
		ifs = {1'b1, seed[2:0]};
		repeat (12) @(negedge clk);
		rst = 0;
		note(ex(0, 0, 0, 2'h0, scsw_pkg::SRC_INT, 0));
		pwr_done = 1;
		repeat (600) @(negedge clk);
		note(ex(0, 0, 0, 2'h0, scsw_pkg::SRC_INT, 1));
		wait_src(scsw_pkg::SRC_EXT, 3000);
		note(ex(1, 0, 0, 2'h0, scsw_pkg::SRC_EXT, 1));
		check({7'h0, hold_seen}, 8'h01);
		$display("End of test: two-speed start-up");
		// New internal choice made while external; the fallback must use it
		seed = lfsr(seed);
		ifs = {1'b1, seed[2:0]};
		irq_en = 1;
		ext_run = 0;
		wait_src(scsw_pkg::SRC_INT, 700);
		note(ex(0, 1, 1, 2'h0, scsw_pkg::SRC_INT, 1));
		check({7'h0, irq}, 8'h01);
		check({4'h0, ifa}, {4'h0, ifs});
		irq_en = 0;
		#1 check({7'h0, irq}, 8'h00);
		repeat (300) @(negedge clk);
		fail_clr = 1;
		@(negedge clk);
		fail_clr = 0;
		note(ex(0, 0, 1, 2'h0, scsw_pkg::SRC_INT, 1));
		$display("End of test: fail-safe detect");
		ext_run = 1;
		pulse_sel(2'h2);
		repeat (40) @(negedge clk);
		note(ex(0, 0, 1, 2'h2, scsw_pkg::SRC_INT, 0));
		repeat (18) @(negedge clk);
		note(ex(0, 0, 0, 2'h2, scsw_pkg::SRC_INT, 1));
		pulse_sel(2'h0);
		wait_src(scsw_pkg::SRC_EXT, 3000);
		note(ex(1, 0, 0, 2'h0, scsw_pkg::SRC_EXT, 1));
		$display("End of test: fail-safe clearing");
		sleep_cmd = 1;
		@(negedge clk);
		sleep_cmd = 0;
		wake_event = 1;
		@(negedge clk);
		wake_event = 0;
		repeat (500) @(negedge clk);
		sleep_cmd = 1;
		@(negedge clk);
		sleep_cmd = 0;
		note(ex(0, 0, 0, 2'h0, scsw_pkg::SRC_INT, 0));
		wake_event = 1;
		@(negedge clk);
		wake_event = 0;
		wait_src(scsw_pkg::SRC_EXT, 3000);
		note(ex(1, 0, 0, 2'h0, scsw_pkg::SRC_EXT, 1));
		$display("End of test: sleep abort");
		sec_en = 1;
		// Ready reads 1 while idle, so look only once the enable was taken
		@(negedge clk);
		check({6'h0, run, rdy}, 8'h02);
		// Software waits for the ready flag before selecting the secondary
		for (i = 0; i < 100 && rdy !== 1'b1; i++) @(negedge clk);
		pulse_sel(2'h1);
		wait_src(scsw_pkg::SRC_SEC, 3000);
		note(ex(0, 0, 0, 2'h1, scsw_pkg::SRC_SEC, 1));
		sec_en = 0;
		// Clear held over the detection edge: the detection must win
		fail_clr = 1;
		wait_src(scsw_pkg::SRC_INT, 700);
		fail_clr = 0;
		note(ex(0, 1, 1, 2'h1, scsw_pkg::SRC_INT, 1));
		check({6'h0, run, rdy}, 8'h01);
		$display("End of test: secondary oscillator");
		restart('{scsw_pkg::MODE_EXT_CLK, 1'b1, 1'b0});
		wait_src(scsw_pkg::SRC_EXT, 20);
		note(ex(1, 0, 0, 2'h0, scsw_pkg::SRC_EXT, 1));
		restart('{scsw_pkg::MODE_INT, 1'b1, 1'b0});
		repeat (60) @(negedge clk);
		note(ex(0, 0, 0, 2'h0, scsw_pkg::SRC_INT, 1));
		restart('{scsw_pkg::MODE_STD_XTAL, 1'b0, 1'b0});
		repeat (300) @(negedge clk);
		note(ex(0, 0, 0, 2'h0, scsw_pkg::SRC_INT, 0));
		clk_en = 0;
		pulse_sel(2'h2);
		note(ex(0, 0, 0, 2'h0, scsw_pkg::SRC_INT, 0));
		clk_en = 1;
		$display("End of test: mode gating");
		end_of_test();
	end
endmodule

// ---- test/scsw_osc_model.sv ----
// Behavioural oscillator set seen by the clock switch
`timescale 1ns/100ps
module scsw_osc_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Controls from the bench
	input wire logic ext_run,
	input wire logic sec_enable,
	// Oscillator levels
	output scsw_pkg::scsw_osc_t osc,
	output logic sec_stable
);
	logic [1:0] lf_div;
	logic [4:0] warm;

	// A dead crystal freezes at its last level, as a real one would
	always_ff @(posedge clk) begin
		if (rst) begin
			osc <= '0;
			lf_div <= 2'h0;
		end else begin
			if (ext_run) begin
				osc.ext <= ~osc.ext;
			end
			osc.sec <= sec_enable ? ~osc.sec : 1'b0;
			osc.intl <= ~osc.intl;
			lf_div <= lf_div + 2'h1;
			osc.lf <= lf_div[1];
		end
	end

	// Secondary needs a warm-up before it reports stable
	always_ff @(posedge clk) begin
		if (rst || !sec_enable) begin
			warm <= 5'h00;
		end else if (warm != 5'h1f) begin
			warm <= warm + 5'h01;
		end
	end
	assign sec_stable = (warm == 5'h1f);
endmodule

// ---- verilog/scsw_clock_switch.sv ----
// System clock source switch with two-speed start-up and fail-safe monitor
`timescale 1ns/100ps
module scsw_clock_switch (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	input wire logic clk_en,
	// Configuration and power events
	input wire scsw_pkg::scsw_cfg_t cfg,
	input wire logic power_delay_done,
	input wire logic sleep_cmd,
	input wire logic wake_event,
	// Software controls
	input wire logic sel_wr,
	input wire logic [1:0] sel_wdata,
	input wire logic [3:0] int_freq_select,
	input wire logic secondary_osc_enable,
	input wire logic osc_fail_irq_enable,
	input wire logic osc_fail_clear,
	// Oscillator levels
	input wire scsw_pkg::scsw_osc_t osc,
	input wire logic sec_osc_stable,
	// Status
	output logic [1:0] sys_clk_select,
	output logic startup_timer_status,
	output logic secondary_osc_ready,
	output logic secondary_osc_run,
	output logic osc_fail_flag,
	output logic osc_fail_irq,
	output logic fail_safe_active,
	output logic [3:0] int_freq_active,
	// Clock control
	output scsw_pkg::scsw_src_t sys_src,
	output logic clk_hold_low,
	output logic cpu_run
);

	typedef enum logic [3:0] {
		ST_PWRUP, ST_SLEEP, ST_START, ST_COUNT, ST_COUNT_INT,
		ST_INT_FALL, ST_HOLD, ST_STAB, ST_EXT, ST_SEC, ST_INT
	} scsw_state_t;

	scsw_state_t state;
	scsw_pkg::scsw_src_t tgt;
	scsw_pkg::scsw_osc_t osc_prev;
	logic [10:0] startup_cnt;
	logic [5:0] stab_cnt;
	logic [5:0] fs_div;
	logic fs_latch;
	logic fs_armed;

	logic ext_fall;
	logic sec_fall;
	logic int_fall;
	logic lf_fall;
	logic lf_rise;
	logic crystal;
	logic two_speed_ok;
	logic sel_change;
	logic cnt_edge;
	logic lf_sel;
	logic stab_step;
	logic [5:0] stab_last;
	logic mon_active;
	logic mon_fall;
	logic sample_rise;
	logic sample_fall;
	logic fail_pulse;

	// Oscillator levels arrive in the clk domain, so edges are plain compares
	assign ext_fall = osc_prev.ext && !osc.ext;
	assign sec_fall = osc_prev.sec && !osc.sec;
	assign int_fall = osc_prev.intl && !osc.intl;
	assign lf_fall = osc_prev.lf && !osc.lf;
	assign lf_rise = !osc_prev.lf && osc.lf;

	assign crystal = (cfg.osc_mode == scsw_pkg::MODE_LOW_XTAL) ||
		(cfg.osc_mode == scsw_pkg::MODE_STD_XTAL) ||
		(cfg.osc_mode == scsw_pkg::MODE_FAST_XTAL);
	assign two_speed_ok = cfg.two_speed && crystal &&
		(sys_clk_select == scsw_pkg::SEL_DEFAULT);

	assign sel_change = sel_wr && (sel_wdata != sys_clk_select);
	assign cnt_edge = (tgt == scsw_pkg::SRC_SEC) ? sec_fall : ext_fall;
	assign lf_sel = (int_freq_select[3:1] == scsw_pkg::IFS_LF_CODE);

	// Stabilization step and length per target
	always_comb begin
		if (tgt == scsw_pkg::SRC_INT) begin
			stab_step = lf_sel ? (lf_fall || (stab_cnt != 6'h00)) : 1'b1;
			stab_last = lf_sel ? scsw_pkg::LF_LAST : scsw_pkg::HF_LAST;
		end else begin
			stab_step = ext_fall;
			stab_last = scsw_pkg::EXT_LAST;
		end
	end

	// Select field moves only on software writes
	always_ff @(posedge clk) begin
		if (rst) begin
			sys_clk_select <= scsw_pkg::SEL_RESET;
		end else if (clk_en && sel_wr) begin
			sys_clk_select <= sel_wdata;
		end
	end

	// Source sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_PWRUP;
			tgt <= scsw_pkg::SRC_INT;
			startup_timer_status <= 1'b0;
			fail_safe_active <= 1'b0;
			startup_cnt <= 11'h000;
			stab_cnt <= 6'h00;
		end else if (clk_en) begin
			if (sleep_cmd) begin
				state <= ST_SLEEP;
				startup_timer_status <= 1'b0;
				fail_safe_active <= 1'b0;
			end else if (sel_change) begin
				state <= ST_START;
				startup_timer_status <= 1'b0;
			end else if (fail_pulse) begin
				state <= ST_INT;
				fail_safe_active <= 1'b1;
				startup_timer_status <= 1'b0;
			end else begin
				case (state)
				ST_PWRUP: begin
					if (power_delay_done) begin
						state <= ST_START;
					end
				end
				ST_SLEEP: begin
					if (wake_event) begin
						state <= ST_START;
					end
				end
				ST_START: begin
					startup_cnt <= 11'h000;
					stab_cnt <= 6'h00;
					if (sys_clk_select[scsw_pkg::SEL_INT_BIT]) begin
						tgt <= scsw_pkg::SRC_INT;
						state <= ST_STAB;
					end else if (sys_clk_select == scsw_pkg::SEL_SECONDARY) begin
						tgt <= scsw_pkg::SRC_SEC;
						state <= ST_COUNT;
					end else if (crystal) begin
						tgt <= scsw_pkg::SRC_EXT;
						state <= two_speed_ok ? ST_COUNT_INT : ST_COUNT;
					end else if (cfg.osc_mode == scsw_pkg::MODE_INT) begin
						tgt <= scsw_pkg::SRC_INT;
						state <= ST_STAB;
					end else begin
						tgt <= scsw_pkg::SRC_EXT;
						state <= ST_STAB;
					end
				end
				ST_COUNT, ST_COUNT_INT: begin
					if (cnt_edge) begin
						startup_cnt <= startup_cnt + 11'h001;
						if (startup_cnt == scsw_pkg::STARTUP_LAST) begin
							if (state == ST_COUNT_INT) begin
								state <= ST_INT_FALL;
							end else if (tgt == scsw_pkg::SRC_SEC) begin
								state <= ST_SEC;
								fail_safe_active <= 1'b0;
							end else begin
								state <= ST_EXT;
								startup_timer_status <= 1'b1;
								fail_safe_active <= 1'b0;
							end
						end
					end
				end
				ST_INT_FALL: begin
					if (int_fall) begin
						state <= ST_HOLD;
						startup_timer_status <= 1'b1;
					end
				end
				ST_HOLD: begin
					if (ext_fall) begin
						state <= ST_EXT;
						fail_safe_active <= 1'b0;
					end
				end
				ST_STAB: begin
					if (stab_step) begin
						stab_cnt <= stab_cnt + 6'h01;
						if (stab_cnt == stab_last) begin
							fail_safe_active <= 1'b0;
							if (tgt == scsw_pkg::SRC_INT) begin
								state <= ST_INT;
							end else begin
								state <= ST_EXT;
								startup_timer_status <= 1'b1;
							end
						end
					end
				end
				default: begin
					// Running states hold until an event
					state <= state;
				end
				endcase
			end
		end
	end

	// Source decode; hold-low stretches the old clock
	always_comb begin
		case (state)
		ST_EXT: sys_src = scsw_pkg::SRC_EXT;
		ST_SEC: sys_src = scsw_pkg::SRC_SEC;
		default: sys_src = scsw_pkg::SRC_INT;
		endcase
	end
	assign clk_hold_low = (state == ST_HOLD);
	// Restart after a failure keeps executing on the internal block while counting, not in ST_STAB
	assign cpu_run = (state == ST_EXT) || (state == ST_SEC) || (state == ST_INT) ||
		(state == ST_COUNT_INT) || (state == ST_INT_FALL) ||
		((state == ST_COUNT) && fail_safe_active);

	// Monitor only once the start-up timer expired
	assign mon_active = cfg.fail_mon && ((state == ST_EXT) || (state == ST_SEC));
	assign mon_fall = (state == ST_SEC) ? sec_fall : ext_fall;
	assign sample_rise = lf_rise && (fs_div == scsw_pkg::FS_RISE);
	assign sample_fall = lf_rise && (fs_div == scsw_pkg::FS_FALL);
	assign fail_pulse = mon_active && fs_armed && sample_fall && !fs_latch && !mon_fall;

	// Fail detector; arming avoids a false trip on a half seen only in part
	always_ff @(posedge clk) begin
		if (rst) begin
			fs_div <= 6'h00;
			fs_latch <= 1'b0;
			fs_armed <= 1'b0;
		end else if (clk_en) begin
			if (lf_rise) begin
				fs_div <= fs_div + 6'h01;
			end
			// Set on external fall, clear on sample rise
			if (mon_fall) begin
				fs_latch <= 1'b1;
			end else if (sample_rise) begin
				fs_latch <= 1'b0;
			end
			if (!mon_active) begin
				fs_armed <= 1'b0;
			end else if (sample_rise) begin
				fs_armed <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			osc_fail_flag <= 1'b0;
		end else if (clk_en) begin
			if (fail_pulse) begin
				osc_fail_flag <= 1'b1;
			end else if (osc_fail_clear) begin
				osc_fail_flag <= 1'b0;
			end
		end
	end
	assign osc_fail_irq = osc_fail_flag && osc_fail_irq_enable;

	// Sampled levels and status copies
	always_ff @(posedge clk) begin
		if (rst) begin
			osc_prev <= '0;
			secondary_osc_run <= 1'b0;
			secondary_osc_ready <= 1'b1;
			int_freq_active <= scsw_pkg::IFS_RESET;
		end else if (clk_en) begin
			osc_prev <= osc;
			secondary_osc_run <= secondary_osc_enable;
			// Ready seen by software; idle secondary reads ready
			secondary_osc_ready <= secondary_osc_enable ? sec_osc_stable : 1'b1;
			if (sys_src == scsw_pkg::SRC_INT) begin
				int_freq_active <= int_freq_select;
			end
		end
	end

	chk_sel_reset: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> sys_clk_select == scsw_pkg::SEL_RESET)
		else $error("select not cleared by reset");
	chk_sel_auto: assert property (@(posedge clk) disable iff (rst)
		clk_en && fail_pulse && !sel_wr |=> $stable(sys_clk_select))
		else $error("automatic switch changed select");
	chk_status_src: assert property (@(posedge clk) disable iff (rst)
		startup_timer_status |-> (state == ST_HOLD) || (state == ST_EXT))
		else $error("status set while not external");
	chk_startup_count: assert property (@(posedge clk) disable iff (rst)
		(state == ST_INT_FALL) && ($past(state) != ST_INT_FALL) |->
		$past(startup_cnt) == scsw_pkg::STARTUP_LAST)
		else $error("start-up count ended early");
	chk_two_speed_mode: assert property (@(posedge clk) disable iff (rst)
		state == ST_COUNT_INT |-> crystal && cfg.two_speed)
		else $error("two-speed outside crystal mode");
	chk_sleep_abort: assert property (@(posedge clk) disable iff (rst)
		clk_en && sleep_cmd |=> (state == ST_SLEEP) && !startup_timer_status)
		else $error("sleep did not abort start-up");
	chk_fail_gate: assert property (@(posedge clk) disable iff (rst)
		fail_pulse |-> cfg.fail_mon && (startup_timer_status || (state == ST_SEC)))
		else $error("failure detected while monitor idle");
	chk_fail_internal: assert property (@(posedge clk) disable iff (rst)
		$rose(fail_safe_active) && !$past(sel_change) |->
		(sys_src == scsw_pkg::SRC_INT) && osc_fail_flag)
		else $error("fail-safe without internal source and flag");
	chk_flag_wins: assert property (@(posedge clk) disable iff (rst)
		clk_en && fail_pulse && osc_fail_clear |=> osc_fail_flag)
		else $error("clear beat a failure");

endmodule

// ---- verilog/scsw_pkg.sv ----
// Constants and types for the system clock switch with fail-safe monitor
// Operation
// - Select 00 uses configured oscillator, 01 secondary, 1x internal block
// - Any reset clears the clock select field to zero
// - Automatic switches never change the clock select field
// - Start-up status is 1 only while holding low before, or running from, the configured external source
// - Secondary oscillator runs only while its enable bit is set
// - Crystal modes count 1024 oscillator cycles before use as system clock
// - Two-speed start-up is off for all non-crystal modes
// - Count reaching 1024 while awake sets status and moves to external clock
// - Sleep during start-up aborts the count and keeps status cleared
// - Two-speed needs switchover bit set, select 00 and crystal mode
// - Two-speed entered after power-up delay and every wake from sleep
// - Run internal, count, wait internal fall, set status, hold, then switch
// - Switch delays: 2 edges for clock inputs, one of each for LF, 2 us HF
// - Monitor watches all external sources, only after start-up timer expired
// - Monitor sample clock is the low-frequency internal clock divided by 64
// - Latch set on external fall, cleared on sample rise, empty half fails
// - Failure moves clock to internal source, sets flag, flag gates interrupt
// - Fail-safe internal frequency is the currently selected internal frequency
// - Stay internal after failure until a restart succeeds
// - Reset, sleep or select change restarts the timer; only reset and sleep clear fail-safe at once
// - Software clears fail flag before switching back; hardware sets it again
package scsw_pkg;

	localparam logic [2:0] MODE_LOW_XTAL = 3'h0;
	localparam logic [2:0] MODE_STD_XTAL = 3'h1;
	localparam logic [2:0] MODE_FAST_XTAL = 3'h2;
	localparam logic [2:0] MODE_EXT_CLK = 3'h3;
	localparam logic [2:0] MODE_INT = 3'h4;
	localparam logic [2:0] MODE_RES_CAP = 3'h5;

	localparam logic [1:0] SEL_DEFAULT = 2'h0;
	localparam logic [1:0] SEL_SECONDARY = 2'h1;
	localparam int SEL_INT_BIT = 1;
	localparam logic [1:0] SEL_RESET = 2'h0;

	localparam logic [3:0] IFS_RESET = 4'h7;
	localparam logic [2:0] IFS_LF_CODE = 3'h0;

	localparam int STARTUP_CYCLES = 1024;
	localparam logic [10:0] STARTUP_LAST = 11'(STARTUP_CYCLES - 1);

	localparam int CLK_PERIOD_NS = 40;
	localparam int HF_DELAY_NS = 2000;
	localparam int HF_DELAY_CYC = (HF_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] HF_LAST = 6'(HF_DELAY_CYC - 1);
	localparam int EXT_STAB_EDGES = 2;
	localparam logic [5:0] EXT_LAST = 6'(EXT_STAB_EDGES - 1);
	localparam logic [5:0] LF_LAST = 6'h01;

	localparam int FS_DIVIDE = 64;
	localparam logic [5:0] FS_RISE = 6'(FS_DIVIDE / 2 - 1);
	localparam logic [5:0] FS_FALL = 6'(FS_DIVIDE - 1);

	typedef enum logic [1:0] {SRC_EXT, SRC_SEC, SRC_INT} scsw_src_t;

	typedef struct packed {
		logic [2:0] osc_mode;
		logic two_speed;
		logic fail_mon;
	} scsw_cfg_t;

	typedef struct packed {
		logic ext;
		logic sec;
		logic intl;
		logic lf;
	} scsw_osc_t;

endpackage
